// [mrf_consts.svh]
// Constants of the Modbus-RTU master framer: register map, status bits,
// function codes, frame layout, CRC and timing figures.
// Assumes it is included once per compilation unit by its bare name.
`ifndef MRF_CONSTS_SVH
`define MRF_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses on the plain register port; WBUF and RBUF are windows selected by reg_addr[7:6]).
// ****************************************************************
`define MRF_OFF_CTRL     8'h00
`define MRF_OFF_ADRFUNC  8'h04
`define MRF_OFF_REGADDR  8'h08
`define MRF_OFF_QTY      8'h0C
`define MRF_OFF_WADDR    8'h10
`define MRF_OFF_WQTY     8'h14
`define MRF_OFF_CFG      8'h18
`define MRF_OFF_REPLY    8'h1C
`define MRF_OFF_WBUF     2'h1
`define MRF_OFF_RBUF     2'h2

// ****************************************************************
// Control and status bit positions.
// ****************************************************************
`define MRF_CTRL_START   0
`define MRF_ST_BUSY      0
`define MRF_ST_DONE      1
`define MRF_ST_ERR       2
`define MRF_ST_EXC       3
`define MRF_ST_TMO       4
`define MRF_ST_BAD       5

// ****************************************************************
// Function codes, request header lengths and reply layout.
// ****************************************************************
`define MRF_FC_RD_COILS  8'h01
`define MRF_FC_RD_HREGS  8'h03
`define MRF_FC_WR_COIL   8'h05
`define MRF_FC_WR_HREG   8'h06
`define MRF_FC_LOOPBACK  8'h08
`define MRF_FC_WR_COILS  8'h0F
`define MRF_FC_WR_HREGS  8'h10
`define MRF_FC_RW_HREGS  8'h17
`define MRF_FC_EXC_FLAG  8'h80
`define MRF_HDR_PLAIN    8'h06
`define MRF_HDR_MULTI    8'h07
`define MRF_HDR_RW       8'h0B
`define MRF_RX_DATA_POS  8'h03
`define MRF_RX_OVERHEAD  8'h05
`define MRF_RX_ECHO_LEN  8'h08

// ****************************************************************
// CRC16 and timing.
// ****************************************************************
`define MRF_CRC_INIT     16'hFFFF
`define MRF_CRC_POLY     16'hA001
`define MRF_CLK_HZ       64'd125000000
`define MRF_BAUD         64'd9600
`define MRF_CHAR_BITS    64'd11
`define MRF_GAP_TENTHS   64'd35
`define MRF_UNIT_MS      64'd100
`define MRF_TMO_DEF_S    16'd2
`define MRF_UNITS_PER_S  16'd10

`endif

// [mrf_pkg.sv]
// Types shared by the Modbus-RTU master framer.
// Assumes mrf_consts.svh supplies the numeric constants.
package mrf_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        MRF_IDLE = 4'b0001,
        MRF_TX   = 4'b0010,
        MRF_WAIT = 4'b0100,
        MRF_RX   = 4'b1000
    } mrf_state_e;

endpackage

// [mrf_master_framer.sv]
// Modbus-RTU master framer: builds a request, sends it byte by byte with
// CRC16, waits for the reply with timeout and retries, checks and strips it.
// Assumes a byte-wide serialiser on tx/rx and a synchronous register master.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "mrf_consts.svh"

module mrf_master_framer
    import mrf_pkg::*;
#(
    parameter int unsigned BUF_WORDS = 8,
    parameter int unsigned GAP_CYC   = int'((`MRF_CLK_HZ * `MRF_GAP_TENTHS * `MRF_CHAR_BITS
                                        + `MRF_BAUD * 64'd10 - 64'd1)
                                        / (`MRF_BAUD * 64'd10)),
    parameter int unsigned UNIT_CYC  = int'(`MRF_CLK_HZ / 64'd1000 * `MRF_UNIT_MS)
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        nrst,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Byte link towards the serialiser.
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    // Status.
    output logic             busy
);

    localparam int IW = (BUF_WORDS > 1) ? $clog2(BUF_WORDS) : 1;
    localparam int RB = 2 * BUF_WORDS;

    typedef struct packed {
        mrf_state_e             st;
        logic [7:0]             slave, func;
        logic [15:0]            raddr, qty, waddr, wqty;
        logic [3:0]             retries;
        logic [15:0]            tmo;
        logic [BUF_WORDS-1:0][15:0] wbuf;
        logic [RB-1:0][7:0]     rbuf;
        logic [7:0]             idx, txb;
        logic [15:0]            crc;
        logic [3:0]             tries;
        logic [15:0]            units;
        logic [31:0]            tick, idle;
        logic [7:0]             rxn;
        logic [15:0]            rcrc;
        logic                   adr_ok;
        logic [7:0]             rfunc, rb2;
        logic [5:0]             stat;
        logic [31:0]            rdata;
    } mrf_state_s;

    mrf_state_s s_reg;
    mrf_state_s s_next;

    // ****************************************************************
    // Frame layout helpers.
    // ****************************************************************
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ `MRF_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
    function automatic logic [7:0] hdr_len(input logic [7:0] fc);
        unique case (fc)
            `MRF_FC_WR_COILS, `MRF_FC_WR_HREGS: hdr_len = `MRF_HDR_MULTI;
            `MRF_FC_RW_HREGS:                   hdr_len = `MRF_HDR_RW;
            default:                            hdr_len = `MRF_HDR_PLAIN;
        endcase
    endfunction
    function automatic logic [7:0] data_len(input mrf_state_s s);
        unique case (s.func)
            `MRF_FC_WR_COILS: data_len = 8'((s.qty + 16'd7) >> 3);
            `MRF_FC_WR_HREGS: data_len = 8'(s.qty << 1);
            `MRF_FC_RW_HREGS: data_len = 8'(s.wqty << 1);
            default:          data_len = 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] frame_byte(input mrf_state_s s, input logic [7:0] i);
        logic [7:0]  k;
        logic [15:0] w;
        k = i - hdr_len(s.func);
        w = s.wbuf[k[IW:1]];
        unique case (i)
            8'h00: frame_byte = s.slave;
            8'h01: frame_byte = s.func;
            8'h02: frame_byte = s.raddr[15:8];
            8'h03: frame_byte = s.raddr[7:0];
            8'h04: frame_byte = s.qty[15:8];
            8'h05: frame_byte = s.qty[7:0];
            default: begin
                if (i == hdr_len(s.func) - 8'h01) begin
                    frame_byte = data_len(s);
                end else if (i < hdr_len(s.func)) begin
                    unique case (i)
                        8'h06:   frame_byte = s.waddr[15:8];
                        8'h07:   frame_byte = s.waddr[7:0];
                        8'h08:   frame_byte = s.wqty[15:8];
                        default: frame_byte = s.wqty[7:0];
                    endcase
                end else begin
                    frame_byte = k[0] ? w[7:0] : w[15:8];
                end
            end
        endcase
    endfunction
    // ****************************************************************
    // Sequencer, register port and reply parser.
    // ****************************************************************
    logic [7:0]  len;
    logic        gap;
    logic        accept;
    logic [15:0] limit;
    logic [IW-1:0] widx;
    logic        in_win;

    assign len    = hdr_len(s_reg.func) + data_len(s_reg);
    assign gap    = (s_reg.idle >= GAP_CYC);
    assign accept = tx_valid && tx_ready;
    // A request with a zero timeout waits two seconds.
    assign limit  = (s_reg.tmo == 16'h0000) ? `MRF_TMO_DEF_S * `MRF_UNITS_PER_S
                                            : s_reg.tmo;
    assign widx   = reg_addr[IW+1:2];
    assign in_win = (32'(reg_addr[5:2]) < BUF_WORDS);
    always_comb begin
        logic        ok, is_read;
        logic [7:0]  n1;
        s_next  = s_reg;
        ok      = 1'b0;
        is_read = (s_reg.func == `MRF_FC_RD_HREGS) || (s_reg.func == `MRF_FC_RD_COILS)
                  || (s_reg.func == `MRF_FC_RW_HREGS);
        n1      = s_reg.idx + 8'h01;
        // Line idle counter saturates once the silent interval is reached.
        if ((rx_valid && s_reg.st != MRF_TX) || accept) begin
            s_next.idle = 32'h0;
        end else if (!gap) begin
            s_next.idle = s_reg.idle + 32'h1;
        end
        // Register writes are taken only while no request is in flight.
        if (reg_wr && s_reg.st == MRF_IDLE) begin
            if (reg_addr[7:6] == `MRF_OFF_WBUF && in_win) begin
                s_next.wbuf[widx] = reg_wdata[15:0];
            end
            unique case (reg_addr)
                `MRF_OFF_ADRFUNC: begin
                    s_next.slave = reg_wdata[15:8];
                    s_next.func  = reg_wdata[7:0];
                end
                `MRF_OFF_REGADDR: s_next.raddr = reg_wdata[15:0];
                `MRF_OFF_QTY:     s_next.qty   = reg_wdata[15:0];
                `MRF_OFF_WADDR:   s_next.waddr = reg_wdata[15:0];
                `MRF_OFF_WQTY:    s_next.wqty  = reg_wdata[15:0];
                `MRF_OFF_CFG: begin
                    s_next.tmo     = reg_wdata[15:0];
                    s_next.retries = reg_wdata[19:16];
                end
                `MRF_OFF_CTRL: begin
                    if (reg_wdata[`MRF_CTRL_START]) begin
                        s_next.st    = MRF_TX;
                        s_next.idx   = 8'h00;
                        s_next.crc   = `MRF_CRC_INIT;
                        s_next.txb   = frame_byte(s_reg, 8'h00);
                        s_next.tries = 4'h0;
                        s_next.stat  = 6'h00;
                    end
                end
                default: ;
            endcase
        end
        unique case (s_reg.st)
            MRF_IDLE: ;
            MRF_TX: begin
                if (accept) begin
                    s_next.idx = n1;
                    if (s_reg.idx < len) begin
                        s_next.crc = crc_upd(s_reg.crc, s_reg.txb);
                    end
                    if (n1 < len) begin
                        s_next.txb = frame_byte(s_reg, n1);
                    end else if (n1 == len) begin
                        s_next.txb = s_next.crc[7:0];
                    end else begin
                        s_next.txb = s_reg.crc[15:8];
                    end
                    if (s_reg.idx == len + 8'h01) begin
                        s_next.st    = MRF_WAIT;
                        s_next.tick  = 32'h0;
                        s_next.units = 16'h0;
                    end
                end
            end
            MRF_WAIT: begin
                if (rx_valid && gap) begin
                    s_next.st     = MRF_RX;
                    s_next.rxn    = 8'h01;
                    s_next.rcrc   = crc_upd(`MRF_CRC_INIT, rx_data);
                    s_next.adr_ok = (rx_data == s_reg.slave);
                end else if (s_reg.units >= limit) begin
                    if (s_reg.tries < s_reg.retries) begin
                        s_next.tries = s_reg.tries + 4'h1;
                        s_next.st    = MRF_TX;
                        s_next.idx   = 8'h00;
                        s_next.crc   = `MRF_CRC_INIT;
                        s_next.txb   = frame_byte(s_reg, 8'h00);
                    end else begin
                        s_next.st = MRF_IDLE;
                        s_next.stat[`MRF_ST_ERR] = 1'b1;
                        s_next.stat[`MRF_ST_TMO] = 1'b1;
                    end
                end else if (s_reg.tick >= UNIT_CYC - 1) begin
                    s_next.tick  = 32'h0;
                    s_next.units = s_reg.units + 16'h1;
                end else begin
                    s_next.tick = s_reg.tick + 32'h1;
                end
            end
            MRF_RX: begin
                if (rx_valid) begin
                    s_next.rxn  = s_reg.rxn + 8'h01;
                    s_next.rcrc = crc_upd(s_reg.rcrc, rx_data);
                    if (s_reg.rxn == 8'h01) begin
                        s_next.rfunc = rx_data;
                    end
                    if (s_reg.rxn == 8'h02) begin
                        s_next.rb2 = rx_data;
                    end
                    // Only bytes below rb2 + 3 are kept: a read reply's CRC falls past that, echo replies keep theirs if rb2 >= 5, exceptions if rb2 >= 2.
                    if (s_reg.rxn >= `MRF_RX_DATA_POS
                        && 32'(s_reg.rxn - `MRF_RX_DATA_POS) < RB
                        && s_reg.rxn < s_reg.rb2 + `MRF_RX_DATA_POS) begin
                        s_next.rbuf[s_reg.rxn - `MRF_RX_DATA_POS] = rx_data;
                    end
                end else if (gap) begin
                    // Frame closed by silence: judge it as a whole.
                    if (s_reg.rcrc != 16'h0000 || !s_reg.adr_ok) begin
                        ok = 1'b0;
                    end else if (s_reg.rfunc == (s_reg.func | `MRF_FC_EXC_FLAG)) begin
                        ok = (s_reg.rxn == `MRF_RX_OVERHEAD);
                    end else if (s_reg.rfunc != s_reg.func) begin
                        ok = 1'b0;
                    end else if (is_read) begin
                        ok = (s_reg.rxn == s_reg.rb2 + `MRF_RX_OVERHEAD)
                             && (s_reg.func == `MRF_FC_RD_COILS
                                 || s_reg.rb2 == 8'(s_reg.qty << 1));
                    end else begin
                        ok = (s_reg.rxn == `MRF_RX_ECHO_LEN);
                    end
                    s_next.st = MRF_IDLE;
                    if (ok) begin
                        s_next.stat[`MRF_ST_DONE] = 1'b1;
                        if (s_reg.rfunc != s_reg.func) begin
                            s_next.stat[`MRF_ST_EXC] = 1'b1;
                            s_next.stat[`MRF_ST_ERR] = 1'b1;
                        end
                    end else begin
                        s_next.stat[`MRF_ST_BAD] = 1'b1;
                        s_next.stat[`MRF_ST_ERR] = 1'b1;
                    end
                end
            end
        endcase
        // Read data is registered and stands one cycle after the strobe.
        s_next.rdata = 32'h0;
        if (reg_rd) begin
            if (reg_addr[7:6] == `MRF_OFF_WBUF && in_win) begin
                s_next.rdata = {16'h0, s_reg.wbuf[widx]};
            end else if (reg_addr[7:6] == `MRF_OFF_RBUF && in_win) begin
                s_next.rdata = {16'h0, s_reg.rbuf[{widx, 1'b0}], s_reg.rbuf[{widx, 1'b1}]};
            end else begin
                unique case (reg_addr)
                    `MRF_OFF_CTRL:    s_next.rdata = {26'h0, s_reg.stat[5:1],
                                                      s_reg.st != MRF_IDLE};
                    `MRF_OFF_ADRFUNC: s_next.rdata = {16'h0, s_reg.slave, s_reg.func};
                    `MRF_OFF_REGADDR: s_next.rdata = {16'h0, s_reg.raddr};
                    `MRF_OFF_QTY:     s_next.rdata = {16'h0, s_reg.qty};
                    `MRF_OFF_WADDR:   s_next.rdata = {16'h0, s_reg.waddr};
                    `MRF_OFF_WQTY:    s_next.rdata = {16'h0, s_reg.wqty};
                    `MRF_OFF_CFG:     s_next.rdata = {12'h0, s_reg.retries, s_reg.tmo};
                    `MRF_OFF_REPLY:   s_next.rdata = {8'h0, s_reg.rxn, s_reg.rfunc, s_reg.rb2};
                    default:          s_next.rdata = 32'h0;
                endcase
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_reg       <= '0;
            s_reg.st    <= MRF_IDLE;
            s_reg.crc   <= `MRF_CRC_INIT;
            s_reg.rcrc  <= `MRF_CRC_INIT;
        end else begin
            s_reg <= s_next;
        end
    end
    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // The first byte of a frame waits for the silent interval on the line.
    assign tx_valid  = (s_reg.st == MRF_TX) && (s_reg.idx != 8'h00 || gap);
    assign tx_data   = s_reg.txb;
    assign reg_rdata = s_reg.rdata;
    assign busy      = (s_reg.st != MRF_IDLE);

endmodule // mrf_master_framer

// [mrf_master_framer_chk.sv]
// Assertions on the ports of the Modbus-RTU master framer, bound to it.
// Assumes one clock and nrst synchronous, active low.
`timescale 1ns/1ps
`include "mrf_consts.svh"

module mrf_master_framer_chk #(
    parameter int unsigned GAP_CYC = 20
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_valid,
    input wire logic        busy
);
    typedef struct packed {
        logic [15:0] line;
        logic [15:0] rx;
    } mrf_quiet_s;
    localparam int GAP_MIN = int'(GAP_CYC) - 1;
    localparam int TX_LIM  = int'(GAP_CYC) + 2;
    mrf_quiet_s q_reg;
    mrf_quiet_s q_next;
    logic       start;
    assign start = reg_wr && reg_addr == `MRF_OFF_CTRL && reg_wdata[0] && !busy;
    // Saturating counts of silent cycles on the whole line and on receive.
    always_comb begin
        q_next = q_reg;
        if (q_reg.line != 16'hFFFF) q_next.line = q_reg.line + 16'h0001;
        if (q_reg.rx != 16'hFFFF) q_next.rx = q_reg.rx + 16'h0001;
        if (rx_valid || (tx_valid && tx_ready)) q_next.line = 16'h0000;
        if (rx_valid) q_next.rx = 16'h0000;
        if (!nrst) q_next = '0;
    end
    always_ff @(posedge clk) begin
        q_reg <= q_next;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_rdata_after_rd: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_tx_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("offered byte changed before accept");
    a_tx_drop_taken: assert property ($fell(tx_valid) |-> $past(tx_ready))
        else $error("byte withdrawn unaccepted");
    a_idle_no_tx: assert property (!busy |-> !tx_valid)
        else $error("byte offered while idle");
    a_start_busy: assert property (start |=> busy)
        else $error("start not taken");
    a_start_sends: assert property (start |-> ##[1:TX_LIM] tx_valid)
        else $error("no byte after start");
    a_gap_first: assert property ($rose(tx_valid) |-> q_reg.line >= GAP_MIN)
        else $error("frame sent without idle gap");
    a_rx_no_tx: assert property (rx_valid |-> !tx_valid)
        else $error("sending while receiving");
    a_end_gap: assert property ($fell(busy) |-> q_reg.rx >= GAP_MIN)
        else $error("request ended inside a frame");
endmodule // mrf_master_framer_chk

bind mrf_master_framer mrf_master_framer_chk #(.GAP_CYC(GAP_CYC)) u_chk (
    .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .busy);

// [mrf_slave_model.sv]
// Slave on the far side of the byte link; replies after a silent gap.
// Assumes mode and slow change only while the link is quiet.
`timescale 1ns/1ps

module mrf_slave_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       nrst,
    // Byte link.
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    // Reply kind: 0 normal, 1 refuse, 2 silent, 3 bad CRC; slow stalls.
    input  wire logic [1:0] mode,
    input  wire logic       slow
);
    logic [7:0]  req[$];
    logic [7:0]  rsp[$];
    logic [15:0] c;
    int          quiet = 0;
    logic        tick = 1'b0;
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] r = 16'hFFFF;
        foreach (b[i]) begin
            r = r ^ {8'h00, b[i]};
            repeat (8) r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
        end
        return r;
    endfunction
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
    end
    assign tx_ready = !slow || tick;
    always @(posedge clk) begin
        tick     <= !tick;
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data; // Released line shows a changing pattern.
        quiet    <= quiet + 1;
        if (!nrst) begin
            req.delete();
            rsp.delete();
        end else if (tx_valid && tx_ready) begin
            req.push_back(tx_data);
            quiet <= 0;
        end else if (quiet == 30 && req.size() > 5) begin
            if (mode == 2'd1) rsp = '{req[0], req[1] | 8'h80, 8'h02};
            else if (req[1] inside {8'h01, 8'h03, 8'h17}) begin
                rsp = '{req[0], req[1], req[5] + req[5]};
                for (int i = 0; i < 2 * req[5]; i++) rsp.push_back(8'hA0 + 8'(i));
            end else rsp = req[0:5];
            c = crc16(rsp);
            if (mode != 2'd2) rsp = {rsp, c[7:0], c[15:8] ^ {8{mode == 2'd3}}};
            else rsp.delete();
            req.delete();
        end else if (rsp.size() > 0 && quiet > 30 && tick) begin
            rx_valid <= 1'b1;
            rx_data  <= rsp.pop_front();
        end
    end
endmodule // mrf_slave_model

// [mrf_master_framer_tb.sv]
// Self-checking bench for the Modbus-RTU master framer and slave model.
// Assumes short gap and time unit so that every request ends quickly.
`timescale 1ns/1ps
`include "mrf_consts.svh"

module mrf_master_framer_tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0]  tx_data, rx_data;
    logic        tx_valid, tx_ready, rx_valid, busy;
    logic [1:0]  mode = 2'h0;
    logic        slow = 1'b0;
    logic [7:0]  sent[$], exp[$];
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc;
    initial begin
        forever #4 clk = ~clk;
    end
    mrf_master_framer #(.BUF_WORDS(8), .GAP_CYC(20), .UNIT_CYC(10)) dut (.clk, .nrst,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_data, .tx_valid,
        .tx_ready, .rx_data, .rx_valid, .busy);
    mrf_slave_model slv (.clk, .nrst, .tx_data, .tx_valid, .tx_ready, .rx_data,
        .rx_valid, .mode, .slow);
    always @(posedge clk) if (tx_valid && tx_ready) sent.push_back(tx_data);
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [5:0] m, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("register", e, m == 6'h0 ? reg_rdata : {26'h0, reg_rdata[5:0]});
        @(posedge clk);
    endtask
    task automatic run(input logic [7:0] fc, input logic [15:0] q, input logic [31:0] cfg,
                       input logic [1:0] md);
        mode <= md;
        sent.delete();
        wr(`MRF_OFF_ADRFUNC, {16'h0001, fc});
        wr(`MRF_OFF_REGADDR, 32'h0000_1016);
        wr(`MRF_OFF_QTY, {16'h0, q});
        wr(`MRF_OFF_WADDR, 32'h0000_2000);
        wr(`MRF_OFF_WQTY, 32'h0000_0001);
        wr(`MRF_OFF_CFG, cfg);
        wr(8'h40, 32'h0000_5A3C);
        wr(`MRF_OFF_CTRL, 32'h0000_0001);
        cyc = 0;
        do begin
            @(posedge clk);
            #1;
            cyc++;
        end while (busy === 1'b1 && cyc < 5000);
        if (cyc >= 5000) begin
            n_errors++;
            $display("unexpected busy expected 0 seen 1");
            close_out();
        end
        // Let the partner finish late work so that a mode change meets a quiet link.
        repeat (40) @(posedge clk);
    endtask
    task automatic frame_ok(input logic [7:0] fc, input logic [15:0] q, input int n);
        logic [15:0] c;
        exp = '{8'h01, fc, 8'h10, 8'h16, q[15:8], q[7:0]};
        if (fc == 8'h17) exp = {exp, 8'h20, 8'h00, 8'h00, 8'h01};
        if (fc == 8'h0F) exp = {exp, 8'h01, 8'h5A};
        if (fc == 8'h10 || fc == 8'h17) exp = {exp, 8'h02, 8'h5A, 8'h3C};
        c = slv.crc16(exp);
        exp = {exp, c[7:0], c[15:8]};
        chk("frame length", n * exp.size(), sent.size());
        foreach (sent[i]) chk("frame byte", {24'h0, exp[i % exp.size()]}, {24'h0, sent[i]});
    endtask
    task automatic t_reset();
        rd(`MRF_OFF_CTRL, 6'h0, 32'h0);
        rd(`MRF_OFF_CFG, 6'h0, 32'h0);
        rd(`MRF_OFF_ADRFUNC, 6'h0, 32'h0);
        rd(8'h3C, 6'h0, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_codes();
        logic [7:0] fcs[8] = '{8'h01, 8'h03, 8'h05, 8'h06, 8'h08, 8'h0F, 8'h10, 8'h17};
        foreach (fcs[i]) begin
            run(fcs[i], 16'h0001, 32'h0, 2'd0);
            frame_ok(fcs[i], 16'h0001, 1);
            rd(`MRF_OFF_CTRL, 6'h3F, 32'h2);
        end
        $display("function code test done");
    endtask
    task automatic t_read();
        slow <= 1'b1;
        run(8'h03, 16'h0002, 32'h0, 2'd0);
        frame_ok(8'h03, 16'h0002, 1);
        rd(`MRF_OFF_REPLY, 6'h0, 32'h0009_0304);
        rd(8'h80, 6'h0, 32'h0000_A0A1);
        rd(8'h84, 6'h0, 32'h0000_A2A3);
        slow <= 1'b0;
        $display("read test done");
    endtask
    task automatic t_refuse();
        run(8'h06, 16'h0001, 32'h0, 2'd1);
        rd(`MRF_OFF_CTRL, 6'h3F, 32'h0E);
        rd(`MRF_OFF_REPLY, 6'h0, 32'h0005_8602);
        $display("refusal test done");
    endtask
    task automatic t_silent(input logic [31:0] cfg, input int n, input int lo, input int hi);
        run(8'h06, 16'h0001, cfg, 2'd2);
        frame_ok(8'h06, 16'h0001, n);
        rd(`MRF_OFF_CTRL, 6'h3F, 32'h14);
        chk("wait span", 32'h1, {31'h0, cyc >= lo && cyc <= hi});
        $display("silence test done");
    endtask
    task automatic t_corrupt();
        run(8'h03, 16'h0001, 32'h000F_0000, 2'd3);
        frame_ok(8'h03, 16'h0001, 1);
        rd(`MRF_OFF_CTRL, 6'h3F, 32'h24);
        $display("corrupt test done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_codes();
        t_read();
        t_refuse();
        t_silent(32'h0, 1, 200, 300);
        t_silent(32'h000F_0001, 16, 160, 1000);
        t_corrupt();
        close_out();
    end
endmodule // mrf_master_framer_tb
